// File: common/wdcm_pkg.sv
/*
  Shared constants and carrier types of the watchdog and clock-mode control block.
  Assumes a single 200 MHz clock and a classic Wishbone register bus.
*/
package wdcm_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] WDCM_IDX_RATIO  = 8'h09;
  localparam logic [7:0] WDCM_IDX_MODE   = 8'h26;
  localparam logic [7:0] WDCM_IDX_STATUS = 8'h0A;
  localparam logic [7:0] WDCM_IDX_CTRL   = 8'h30;
  // reset values
  localparam logic [7:0] WDCM_RATIO_RST  = 8'h07;
  localparam logic [7:0] WDCM_MODE_RST   = 8'h00;
  // field positions
  localparam int WDCM_MODE_FREQ_MULTIPLIER_ENABLE_BIT  = 5;
  localparam int WDCM_MODE_HALT_BIT  = 6;
  localparam int WDCM_MODE_FAST_BIT  = 7;
  localparam int WDCM_STAT_PDF_BIT   = 4;
  localparam int WDCM_STAT_TO_BIT    = 5;
  // control register bits: one-shot operations written by the core model
  localparam int WDCM_CTRL_CLR_BIT   = 0;
  localparam int WDCM_CTRL_CLR1_BIT  = 1;
  localparam int WDCM_CTRL_CLR2_BIT  = 2;
  localparam int WDCM_CTRL_HALT_BIT  = 3;
  localparam int WDCM_CTRL_WAKE_BIT  = 4;
  // timing
  localparam int WDCM_FIX_STAGES     = 9;
  localparam int WDCM_PRE_STAGES     = 7;
  localparam int WDCM_INSTR_DIV      = 4;
  localparam int WDCM_SST_PULSES     = 1024;
  localparam int WDCM_CLK_MHZ        = 200;
  localparam int WDCM_RC_PERIOD_NS   = 78000;
  localparam int WDCM_RC_CYCLES      = WDCM_RC_PERIOD_NS * WDCM_CLK_MHZ / 1000;
  localparam int WDCM_XTAL_HZ        = 32768;
  localparam int WDCM_XTAL_CYCLES    = WDCM_CLK_MHZ * 1000000 / WDCM_XTAL_HZ;

  typedef enum logic [1:0] {
    WDCM_SRC_RC    = 2'h0,
    WDCM_SRC_XTAL  = 2'h1,
    WDCM_SRC_INSTR = 2'h2
  } wdcm_src_t;

  typedef enum logic [1:0] {
    WDCM_GREEN  = 2'h0,
    WDCM_NORMAL = 2'h1,
    WDCM_IDLE   = 2'h3,
    WDCM_SLEEP  = 2'h2
  } wdcm_mode_t;

  typedef struct packed {
    logic        clear_op;
    logic        first_op;
    logic        second_op;
    logic        halt_op;
    logic        wake_op;
  } wdcm_ops_t;
endpackage

// File: core/wdcm_divider.sv
/*
  Free-running divider that gives a one-cycle enable pulse every DIV cycles.
  Assumes the single system clock; run low holds it cleared.
*/
`timescale 1ns/10ps
module wdcm_divider #(
  parameter int DIV = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      tick_o
);
  localparam int W = $clog2(DIV + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } wdcm_div_state_t;

  wdcm_div_state_t s_reg;
  wdcm_div_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run_i) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt == W'(DIV - 1)) begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;
endmodule

// File: core/wdcm_top.sv
/*
  Watchdog timer with its operating-mode control, reached over classic Wishbone.
  Assumes one 200 MHz clock, synchronous inputs and a core that reports its
  clear, halt and wake operations through the control register or op strobes.
*/
// The Wishbone interface to the registers was chosen for this implementation.
// Operation
// - rc oscillator off unless enabled and selected
// - build option picks rc, crystal or instruction
// - disabled watchdog ignores every watchdog operation
// - fixed divide by 512 first
// - prescaler ratio is two to select value
// - ratio register bits 7..3 plain storage
// - instruction clock stops in sleep and idle
// - crystal clock counts sleep, stops idle
// - rc oscillator runs in every mode
// - timeout in normal/green: chip reset, flag
// - timeout in sleep/idle: warm reset, both flags
// - pin, clear op or halt clear counter
// - one scheme; single op always clears
// - two-op scheme needs both ops to clear
// - green after reset or wake-up
// - leaving fast clock keeps multiplier enable
// - mode bit 5 enables frequency multiplier
// - mode bit 6 selects idle or sleep
// - mode bit 7 selects fast system clock
// - mode bits 4..0 read zero
// - halt sets power-down, clears expiry flag
// - 1024 system clock start-up delay
`timescale 1ns/10ps
module wdcm_top
  import wdcm_pkg::*;
#(
  parameter bit        WDT_ENABLE  = 1'b1,
  parameter wdcm_src_t WDT_SOURCE  = WDCM_SRC_RC,
  parameter bit        TWO_OP      = 1'b0,
  parameter int        RC_CYCLES   = WDCM_RC_CYCLES,
  parameter int        XTAL_CYCLES = WDCM_XTAL_CYCLES,
  parameter int        SST_PULSES  = WDCM_SST_PULSES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_clear_pin_n_i,
  input  wire wdcm_ops_t   ops_i,
  output logic             watchdog_rc_oscillator_en_o,
  output logic             freq_multiplier_en_o,
  output logic             fast_clock_o,
  output logic             xtal_run_o,
  output logic             sys_clock_run_o,
  output logic             chip_reset_o,
  output logic             warm_reset_o,
  output logic             startup_busy_o,
  output wdcm_mode_t       op_mode_o
);
  localparam int CW = WDCM_FIX_STAGES + WDCM_PRE_STAGES;
  localparam int SW = $clog2(SST_PULSES + 1);

  typedef struct packed {
    logic [7:0]  ratio;
    logic        freq_multiplier_enable;
    logic        halt_osc_stop_select;
    logic        fast_clock_select;
    logic        expiry_flag;
    logic        power_down_flag;
    wdcm_mode_t  mode;
    logic [CW:0] count;
    logic        first_seen;
    logic        second_seen;
    logic        chip_rst;
    logic        warm_rst;
    logic [SW-1:0] startup_delay_timer;
    logic        ack;
    logic [31:0] rdata;
  } wdcm_state_t;

  wdcm_state_t s_reg;
  wdcm_state_t s_next;

  logic       rc_tick;
  logic       xtal_tick;
  logic       instr_tick;
  logic       wd_tick;
  logic       halted;
  logic       rc_on;
  logic       sys_run;
  logic [7:0] adr_idx;
  logic       wb_req;
  logic       wb_wr;
  wdcm_ops_t  ops;
  logic [7:0] wr_byte;

  assign halted  = (s_reg.mode == WDCM_SLEEP) || (s_reg.mode == WDCM_IDLE);
  assign rc_on   = WDT_ENABLE && (WDT_SOURCE == WDCM_SRC_RC);
  assign sys_run = !halted;

  wdcm_divider #(.DIV(RC_CYCLES)) u_rc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (rc_on),
    .tick_o (rc_tick)
  );

  // crystal halts only in idle; its timer stands in for the 32768 Hz source
  wdcm_divider #(.DIV(XTAL_CYCLES)) u_xtal (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (s_reg.mode != WDCM_IDLE),
    .tick_o (xtal_tick)
  );

  // instruction clock is the system clock over four and stops on halt
  wdcm_divider #(.DIV(WDCM_INSTR_DIV)) u_instr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (sys_run),
    .tick_o (instr_tick)
  );

  always_comb begin
    unique case (WDT_SOURCE)
      WDCM_SRC_XTAL:  wd_tick = xtal_tick && (s_reg.mode != WDCM_IDLE);
      WDCM_SRC_INSTR: wd_tick = instr_tick && !halted;
      default:        wd_tick = rc_tick;
    endcase
  end

  assign adr_idx = wb_adr_i[9:2];
  assign wb_req  = wb_cyc_i && wb_stb_i && !s_reg.ack;
  assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  // operations come from the op port or a write to the control register
  always_comb begin
    ops = ops_i;
    if (wb_wr && adr_idx == WDCM_IDX_CTRL) begin
      ops.clear_op  = ops_i.clear_op  | wr_byte[WDCM_CTRL_CLR_BIT];
      ops.first_op  = ops_i.first_op  | wr_byte[WDCM_CTRL_CLR1_BIT];
      ops.second_op = ops_i.second_op | wr_byte[WDCM_CTRL_CLR2_BIT];
      ops.halt_op   = ops_i.halt_op   | wr_byte[WDCM_CTRL_HALT_BIT];
      ops.wake_op   = ops_i.wake_op   | wr_byte[WDCM_CTRL_WAKE_BIT];
    end
  end

  always_comb begin
    logic sw_clear;
    logic wd_clear;
    logic f_seen;
    logic s_seen;
    logic halt_now;
    logic timeout;
    logic [CW:0] limit;
    sw_clear = 1'b0;
    wd_clear = 1'b0;
    f_seen   = 1'b0;
    s_seen   = 1'b0;
    halt_now = 1'b0;
    timeout  = 1'b0;
    limit    = '0;
    s_next = s_reg;
    s_next.chip_rst = 1'b0;
    s_next.warm_rst = 1'b0;
    s_next.ack = wb_req;

    halt_now = ops.halt_op && !halted && (s_reg.startup_delay_timer == '0);
    if (TWO_OP) begin
      f_seen = s_reg.first_seen | ops.first_op;
      s_seen = s_reg.second_seen | ops.second_op;
      sw_clear = f_seen && s_seen;
    end else begin
      sw_clear = ops.clear_op;
    end
    if (!WDT_ENABLE) begin
      sw_clear = 1'b0;
    end
    // the low pin level holds the counter cleared as long as it lasts
    wd_clear = !ext_clear_pin_n_i || sw_clear || (halt_now && WDT_ENABLE);
    s_next.first_seen  = TWO_OP && WDT_ENABLE && f_seen && !wd_clear;
    s_next.second_seen = TWO_OP && WDT_ENABLE && s_seen && !wd_clear;

    limit = (CW + 1)'(1) << (WDCM_FIX_STAGES + s_reg.ratio[2:0]);
    if (!WDT_ENABLE || wd_clear) begin
      s_next.count = '0;
    end else if (wd_tick) begin
      if (s_reg.count + (CW + 1)'(1) >= limit) begin
        timeout = 1'b1;
        s_next.count = '0;
      end else begin
        s_next.count = s_reg.count + (CW + 1)'(1);
      end
    end

    if (sw_clear) begin
      s_next.expiry_flag = 1'b0;
    end

    if (halt_now) begin
      s_next.power_down_flag = 1'b1;
      s_next.expiry_flag = 1'b0;
      s_next.mode = s_reg.halt_osc_stop_select ? WDCM_IDLE : WDCM_SLEEP;
      s_next.fast_clock_select = 1'b0;
    end

    if (timeout) begin
      s_next.expiry_flag = 1'b1;
      s_next.mode = WDCM_GREEN;
      s_next.startup_delay_timer = SW'(SST_PULSES);
      if (halted) begin
        s_next.warm_rst = 1'b1;
        s_next.power_down_flag = 1'b1;
      end else begin
        s_next.chip_rst = 1'b1;
        s_next.ratio = WDCM_RATIO_RST;
        s_next.freq_multiplier_enable = WDCM_MODE_RST[WDCM_MODE_FREQ_MULTIPLIER_ENABLE_BIT];
        s_next.halt_osc_stop_select = WDCM_MODE_RST[WDCM_MODE_HALT_BIT];
        s_next.fast_clock_select = WDCM_MODE_RST[WDCM_MODE_FAST_BIT];
      end
    end else if (ops.wake_op && halted) begin
      s_next.mode = WDCM_GREEN;
      s_next.startup_delay_timer = SW'(SST_PULSES);
    end else if (s_reg.startup_delay_timer != '0) begin
      s_next.startup_delay_timer = s_reg.startup_delay_timer - SW'(1);
    end

    if (wb_wr && !timeout) begin
      unique case (adr_idx)
        WDCM_IDX_RATIO: s_next.ratio = wr_byte;
        WDCM_IDX_MODE: begin
          s_next.freq_multiplier_enable = wr_byte[WDCM_MODE_FREQ_MULTIPLIER_ENABLE_BIT];
          s_next.halt_osc_stop_select = wr_byte[WDCM_MODE_HALT_BIT];
          // software must have had the multiplier on for 20 ms before this
          s_next.fast_clock_select = wr_byte[WDCM_MODE_FAST_BIT];
          if (!halted && !halt_now) begin
            // multiplier enable left as written, fast select alone decides
            s_next.mode = wr_byte[WDCM_MODE_FAST_BIT] ? WDCM_NORMAL : WDCM_GREEN;
          end
        end
        default: ;
      endcase
    end

    s_next.rdata = '0;
    if (wb_req && !wb_we_i) begin
      unique case (adr_idx)
        WDCM_IDX_RATIO: s_next.rdata[7:0] = s_reg.ratio;
        WDCM_IDX_MODE: begin
          s_next.rdata[WDCM_MODE_FREQ_MULTIPLIER_ENABLE_BIT] = s_reg.freq_multiplier_enable;
          s_next.rdata[WDCM_MODE_HALT_BIT] = s_reg.halt_osc_stop_select;
          s_next.rdata[WDCM_MODE_FAST_BIT] = s_reg.fast_clock_select;
        end
        WDCM_IDX_STATUS: begin
          s_next.rdata[WDCM_STAT_PDF_BIT] = s_reg.power_down_flag;
          s_next.rdata[WDCM_STAT_TO_BIT] = s_reg.expiry_flag;
        end
        WDCM_IDX_CTRL: s_next.rdata[1:0] = s_reg.mode;
        default: ;
      endcase
    end
  end

  // power-up reset: green mode, flags clear, start-up delay armed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg       <= '0;
      s_reg.ratio <= WDCM_RATIO_RST;
      s_reg.mode  <= WDCM_GREEN;
      s_reg.startup_delay_timer   <= SW'(SST_PULSES);
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o                    = s_reg.ack;
  assign wb_dat_o                    = s_reg.rdata;
  assign watchdog_rc_oscillator_en_o = rc_on;
  assign freq_multiplier_en_o        = s_reg.freq_multiplier_enable;
  assign fast_clock_o                = s_reg.mode == WDCM_NORMAL;
  assign xtal_run_o                  = s_reg.mode != WDCM_IDLE;
  assign sys_clock_run_o             = sys_run && (s_reg.startup_delay_timer == '0);
  assign chip_reset_o                = s_reg.chip_rst;
  assign warm_reset_o                = s_reg.warm_rst;
  assign startup_busy_o              = s_reg.startup_delay_timer != '0;
  assign op_mode_o                   = s_reg.mode;
endmodule

// File: verif/tb.sv
/*
  Self-checking bench for wdcm_top: Wishbone register access and op pulses.
  Assumes short counts (rc tick 3, start-up 8) so a ratio-0 timeout takes ~1.5k cycles, ratio 1 ~3k.
*/
`timescale 1ns/10ps
module tb;
  import wdcm_pkg::*;
  localparam int RCC = 3;
  logic        clk_i, rst_i, cyc, stb, we, pin_n;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dat_o;
  logic        ack, rc_en, fm_en, fast, xrun, srun, chip_rst, warm_rst, busy;
  wdcm_mode_t  mode;
  wdcm_ops_t   ops;
  int          num_errors = 0, n_checks = 0, cyc_cnt = 0, n_rst = 0, n;

  wdcm_top #(.RC_CYCLES(RCC), .XTAL_CYCLES(5), .SST_PULSES(8)) wdcm_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_clear_pin_n_i(pin_n), .ops_i(ops), .watchdog_rc_oscillator_en_o(rc_en),
    .freq_multiplier_en_o(fm_en), .fast_clock_o(fast), .xtal_run_o(xrun),
    .sys_clock_run_o(srun), .chip_reset_o(chip_rst), .warm_reset_o(warm_rst),
    .startup_busy_o(busy), .op_mode_o(mode));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ceiling well above the ~12k cycles the sequence needs
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (chip_rst === 1'b1 || warm_rst === 1'b1)
      n_rst++;
    if (cyc_cnt == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
            input logic [3:0] s = 4'hF);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
    xfer(1'b0, idx, 8'h00);
    chk(nm, {24'h000000, e}, rdat);
  endtask

  task op(input wdcm_ops_t v);
    ops <= v;
    @(posedge clk_i);
    ops <= '0;
    @(posedge clk_i);
  endtask

  // cycles from the clearing event until a reset pulse, checked against the rc count
  task timeout(input int r);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (chip_rst !== 1'b1 && warm_rst !== 1'b1 && n < 9000);
    chk("timeout window", 1, (n > 512 * RCC * (1 << r) - 8) && (n < 512 * RCC * (1 << r) + 8));
  endtask

  initial begin
    {rst_i, pin_n} = 2'b11;
    {cyc, stb, we, sel, adr, wdat, ops} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(WDCM_IDX_RATIO, WDCM_RATIO_RST, "ratio reset");
    rd(WDCM_IDX_MODE, WDCM_MODE_RST, "mode reset");
    rd(8'h3F, 8'h00, "unmapped read");
    chk("rc enable", 1, rc_en);
    $display("test reset done");
    xfer(1'b1, WDCM_IDX_RATIO, 8'hF8);
    rd(WDCM_IDX_RATIO, 8'hF8, "ratio flags");
    xfer(1'b1, WDCM_IDX_RATIO, 8'h55, 4'hE);
    rd(WDCM_IDX_RATIO, 8'hF8, "byte lane off");
    xfer(1'b1, WDCM_IDX_MODE, 8'h3F);
    chk("multiplier first", {2'b10, WDCM_GREEN}, {fm_en, fast, mode});
    // scaled settling time of the multiplier before the fast select
    repeat (20) @(posedge clk_i);
    xfer(1'b1, WDCM_IDX_MODE, 8'hFF);
    rd(WDCM_IDX_MODE, 8'hE0, "mode readback");
    chk("normal", {2'b11, WDCM_NORMAL}, {fm_en, fast, mode});
    xfer(1'b1, WDCM_IDX_MODE, 8'h60);
    chk("back to green", {2'b10, WDCM_GREEN}, {fm_en, fast, mode});
    xfer(1'b1, WDCM_IDX_MODE, 8'h00);
    chk("multiplier off", 0, fm_en);
    $display("test mode done");
    repeat (3) begin
      repeat (1200) @(posedge clk_i);
      xfer(1'b1, WDCM_IDX_CTRL, 8'h01);
    end
    pin_n <= 1'b0;
    repeat (2000) @(posedge clk_i);
    pin_n <= 1'b1;
    chk("no reset while cleared", 0, n_rst);
    $display("test clear done");
    op(5'b10000);
    timeout(0);
    chk("chip reset", 1, chip_rst);
    rd(WDCM_IDX_STATUS, 8'h20, "expiry flag");
    rd(WDCM_IDX_RATIO, WDCM_RATIO_RST, "ratio restored");
    xfer(1'b1, WDCM_IDX_RATIO, 8'h01);
    op(5'b10000);
    timeout(1);
    $display("test timeout done");
    while (busy === 1'b1)
      @(posedge clk_i);
    xfer(1'b1, WDCM_IDX_RATIO, 8'h00);
    op(5'b00010);
    chk("sleep", WDCM_SLEEP, mode);
    rd(WDCM_IDX_STATUS, 8'h10, "halt flags");
    timeout(0);
    chk("warm reset", 1, warm_rst);
    rd(WDCM_IDX_STATUS, 8'h30, "warm flags");
    rd(WDCM_IDX_RATIO, 8'h00, "ratio kept");
    while (busy === 1'b1)
      @(posedge clk_i);
    xfer(1'b1, WDCM_IDX_MODE, 8'h40);
    op(5'b00010);
    chk("idle", {WDCM_IDLE, 1'b0}, {mode, xrun});
    rd(WDCM_IDX_CTRL, {6'h00, WDCM_IDLE}, "mode code");
    op(5'b00001);
    chk("wake green", {WDCM_GREEN, 1'b1}, {mode, busy});
    n = 0;
    while (busy === 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk("start-up length", 1, n > 4 && n < 9);
    $display("test halt done");
    end_of_test();
  end
endmodule

// File: verif/wdcm_top_props.sv
/*
  Port checker for wdcm_top, bound into the design.
  Assumes the bench start-up count of 8 and an rc watchdog source.
*/
`timescale 1ns/10ps
module wdcm_top_props
  import wdcm_pkg::*;
#(
  parameter bit        WDT_ENABLE = 1'b1,
  parameter wdcm_src_t WDT_SOURCE = WDCM_SRC_RC
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire wdcm_ops_t   ops_i,
  input wire logic        watchdog_rc_oscillator_en_o,
  input wire logic        fast_clock_o,
  input wire logic        xtal_run_o,
  input wire logic        sys_clock_run_o,
  input wire logic        chip_reset_o,
  input wire logic        warm_reset_o,
  input wire logic        startup_busy_o,
  input wire wdcm_mode_t  op_mode_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one cycle answer");
  chk_mode_low_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == WDCM_IDX_MODE
    |-> wb_dat_o[4:0] == 5'h00) else $error("mode low bits not zero");
  chk_rc_osc_gate: assert property (watchdog_rc_oscillator_en_o
    == (WDT_ENABLE && WDT_SOURCE == WDCM_SRC_RC)) else $error("rc enable wrong");
  chk_chip_rst_awake: assert property (chip_reset_o
    |-> $past(op_mode_o) inside {WDCM_GREEN, WDCM_NORMAL} ##1 !chip_reset_o)
    else $error("chip reset out of place");
  chk_warm_rst_halted: assert property (warm_reset_o
    |-> $past(op_mode_o) inside {WDCM_SLEEP, WDCM_IDLE} ##1 !warm_reset_o)
    else $error("warm reset out of place");
  chk_rst_to_green: assert property (chip_reset_o || warm_reset_o
    |-> ##[0:1] (op_mode_o == WDCM_GREEN && startup_busy_o))
    else $error("no green start after reset");
  chk_halt_entry: assert property (ops_i.halt_op && sys_clock_run_o
    |=> op_mode_o inside {WDCM_SLEEP, WDCM_IDLE} && !sys_clock_run_o)
    else $error("halt not entered");
  chk_xtal_idle: assert property (xtal_run_o == (op_mode_o != WDCM_IDLE))
    else $error("crystal run wrong");
  chk_fast_normal: assert property (fast_clock_o == (op_mode_o == WDCM_NORMAL))
    else $error("fast clock wrong");
  chk_startup_ends: assert property ($fell(rst_i) |-> ##[1:12] !startup_busy_o)
    else $error("start-up delay too long");
  chk_busy_halts_cpu: assert property (startup_busy_o |-> !sys_clock_run_o)
    else $error("cpu runs during start-up");
  chk_fast_by_write: assert property ($rose(fast_clock_o) |-> $past(wb_cyc_i && wb_stb_i
    && wb_we_i && wb_adr_i[9:2] == WDCM_IDX_MODE))
    else $error("fast clock without mode write");
  chk_idle_by_halt: assert property ($fell(xtal_run_o) |-> $past(ops_i.halt_op
    || (wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[9:2] == WDCM_IDX_CTRL)))
    else $error("idle entered without halt");

  cover property (chip_reset_o);
  cover property (warm_reset_o);
  cover property (op_mode_o == WDCM_IDLE);
endmodule

bind wdcm_top wdcm_top_props #(.WDT_ENABLE(WDT_ENABLE), .WDT_SOURCE(WDT_SOURCE)) props_inst (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ops_i,
  .watchdog_rc_oscillator_en_o, .fast_clock_o, .xtal_run_o, .sys_clock_run_o,
  .chip_reset_o, .warm_reset_o, .startup_busy_o, .op_mode_o
);
